// ### logic/dsc_pkg.sv
package dsc_pkg;
	// ==========================================
	// word layout
	localparam int WORD_BITS  = 24;             // bits acted upon
	localparam int LONG_BITS  = 32;             // padded word length
	localparam int PAD_BITS   = 8;              // leading ignored bits in long form
	localparam int CMD_MSB    = 23;             // command code position
	localparam int CMD_LSB    = 20;
	localparam int ADDR_MSB   = 19;             // channel address position
	localparam int ADDR_LSB   = 16;
	localparam int DATA_BITS  = 16;             // data field width
	localparam logic [15:0] CODE_RESET = 16'h0000; // zero scale
	// ==========================================
	// command codes
	localparam logic [3:0] CMD_WRITE      = 4'h0;
	localparam logic [3:0] CMD_UPDATE     = 4'h1;
	localparam logic [3:0] CMD_WRITE_ALL  = 4'h2;
	localparam logic [3:0] CMD_WRITE_UPD  = 4'h3;
	localparam logic [3:0] CMD_POWER_DOWN = 4'h4;
	localparam logic [3:0] CMD_NOP        = 4'hF;
	// ==========================================
	// channel addresses
	localparam logic [3:0] ADDR_A   = 4'h0;
	localparam logic [3:0] ADDR_B   = 4'h1;
	localparam logic [3:0] ADDR_ALL = 4'hF;
	// ==========================================
	// power-up delays
	localparam int CLK_MHZ        = 200;        // system clock rate
	localparam int WAKE_ONE_US    = 5;          // one channel was down
	localparam int WAKE_BOTH5_US  = 12;         // both down, 5 V supply
	localparam int WAKE_BOTH3_US  = 30;         // both down, 3 V supply
	localparam int WAKE_ONE_CYC   = WAKE_ONE_US * CLK_MHZ;
	localparam int WAKE_BOTH5_CYC = WAKE_BOTH5_US * CLK_MHZ;
	localparam int WAKE_BOTH3_CYC = WAKE_BOTH3_US * CLK_MHZ;
	// ==========================================
	// host link timing
	localparam int SCK_HALF_CYC   = 8;          // 40 ns high, 40 ns low
	// ==========================================
	// axi-lite offsets of the host registers
	localparam logic [7:0] OFF_CMD    = 8'h00;  // write: [23:0] word, [31] long form
	localparam logic [7:0] OFF_STATUS = 8'h04;  // read: [0] busy
endpackage : dsc_pkg

// ### logic/dsc_link_if.sv
interface dsc_link_if;
	// ==========================================
	// three-wire link
	logic select_load_n;    // level chip select / load, low active
	logic sck;              // serial clock from host
	logic serial_data_in;   // data into device
	modport host   (output select_load_n, output sck, output serial_data_in);
	modport device (input select_load_n, input sck, input serial_data_in);
endinterface : dsc_link_if

// ### logic/dsc_device.sv
// The register addresses and the AXI4-Lite interface to the registers were decided locally.
module dsc_device #(
	parameter int WAKE_ONE   = dsc_pkg::WAKE_ONE_CYC,   // single wake cycles
	parameter int WAKE_BOTH5 = dsc_pkg::WAKE_BOTH5_CYC, // both down, 5 V
	parameter int WAKE_BOTH3 = dsc_pkg::WAKE_BOTH3_CYC  // both down, 3 V
) (
	// clock and reset
	input  wire logic        CLK,
	input  wire logic        RST,
	// link
	dsc_link_if.device       LINK,
	// supply selection for wake delay
	input  wire logic        SUPPLY_LOW,
	// channel outputs
	output logic [15:0]      CODE_A,
	output logic [15:0]      CODE_B,
	output logic             DOWN_A,
	output logic             DOWN_B,
	output logic             SETTLED
);
	import dsc_pkg::*;

	// ==========================================
	// pin synchronisers
	logic [2:0]  sel_sync;           // select_load_n, three stages
	logic [2:0]  sck_sync;           // sck, three stages
	logic [2:0]  sdi_sync;           // data, three stages
	logic        sel_n;              // accepted select level
	logic        sck_lvl;            // accepted sck level
	logic        sdi_lvl;            // data at accepted point

	// three stages, a change counts when 2nd and 3rd agree
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			sel_sync <= 3'h7;
			sck_sync <= 3'h0;
			sdi_sync <= 3'h0;
		end else begin
			sel_sync <= {sel_sync[1:0], LINK.select_load_n};
			sck_sync <= {sck_sync[1:0], LINK.sck};
			sdi_sync <= {sdi_sync[1:0], LINK.serial_data_in};
		end
	end

	// debounced levels, updated only on agreement
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			sel_n   <= 1'b1;
			sck_lvl <= 1'b0;
			sdi_lvl <= 1'b0;
		end else begin
			if (sel_sync[1] == sel_sync[2])
				sel_n <= sel_sync[2];
			if (sck_sync[1] == sck_sync[2])
				sck_lvl <= sck_sync[2];
			// data follows the same agreement rule as sck
			if (sdi_sync[1] == sdi_sync[2])
				sdi_lvl <= sdi_sync[2];
		end
	end

	// edge events
	logic sck_rise;                  // rising link clock
	logic sel_rise;                  // end of frame
	logic sck_prev;
	logic sel_prev;
	assign sck_rise = sck_lvl & ~sck_prev;
	assign sel_rise = sel_n & ~sel_prev;

	// previous levels for edge detection
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			sck_prev <= 1'b0;
			sel_prev <= 1'b1;
		end else begin
			sck_prev <= sck_lvl;
			sel_prev <= sel_n;
		end
	end

	// ==========================================
	// shift register
	// only the last 24 bits kept; padding simply falls off the top
	logic [WORD_BITS-1:0] shift;     // received word
	logic [5:0]           nbits;     // bits seen this frame, saturating

	// shift on rising sck while selected
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			shift <= '0;
			nbits <= 6'h00;
		end else if (sel_n) begin
			// sck ignored while deselected
			if (sel_rise)
				nbits <= 6'h00;
		end else if (sck_rise) begin
			// one bit per edge, msb first
			shift <= {shift[WORD_BITS-2:0], sdi_lvl};
			if (nbits != 6'h3F)
				nbits <= nbits + 6'h01;
		end
	end

	// ==========================================
	// decode
	logic [3:0]  command_code;       // top nibble
	logic [3:0]  channel_address;    // second nibble
	logic [15:0] data_field;         // low 16 bits
	logic [1:0]  sel_ch;             // addressed channels, bit0 = A
	logic        do_write;
	logic        do_update;
	logic        upd_all;
	logic        do_down;
	logic        frame_ok;           // at least a full word seen

	assign command_code    = shift[CMD_MSB:CMD_LSB];
	assign channel_address = shift[ADDR_MSB:ADDR_LSB];
	assign data_field      = shift[DATA_BITS-1:0];
	assign frame_ok        = (nbits >= 6'(WORD_BITS));

	// command and address decoding
	always_comb begin
		case (channel_address)
			ADDR_A:   sel_ch = 2'b01;
			ADDR_B:   sel_ch = 2'b10;
			ADDR_ALL: sel_ch = 2'b11;
			default:  sel_ch = 2'b00;   // reserved, nothing addressed
		endcase
		do_write  = 1'b0;
		do_update = 1'b0;
		upd_all   = 1'b0;
		do_down   = 1'b0;
		case (command_code)
			CMD_WRITE:      do_write = 1'b1;
			CMD_UPDATE:     do_update = 1'b1;
			CMD_WRITE_ALL: begin
				do_write = 1'b1;
				upd_all  = 1'b1;
			end
			CMD_WRITE_UPD: begin
				do_write  = 1'b1;
				do_update = 1'b1;
			end
			CMD_POWER_DOWN: do_down = 1'b1;
			default:        ;           // no-op and reserved codes
		endcase
	end

	// ==========================================
	// channel registers
	logic [15:0] in_reg [2];         // input registers
	logic [15:0] dac_reg [2];        // active codes
	logic [1:0]  down;               // power-down flags
	logic [1:0]  upd_ch;             // channels updated this frame
	logic        exec;               // execute strobe

	assign exec   = sel_rise & frame_ok;
	assign upd_ch = upd_all ? 2'b11 : (do_update ? sel_ch : 2'b00);

	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_ch
			// write, update and power-down per channel
			always_ff @(posedge CLK or posedge RST) begin
				if (RST) begin
					in_reg[g]  <= CODE_RESET;   // zero scale
					dac_reg[g] <= CODE_RESET;
					down[g]    <= 1'b0;
				end else if (exec) begin
					// write copies data field
					if (do_write && sel_ch[g])
						in_reg[g] <= data_field;
					// update sees the new value on combined commands
					if (upd_ch[g])
						dac_reg[g] <= (do_write && sel_ch[g]) ? data_field : in_reg[g];
					// flag set ignores data, registers untouched
					if (do_down && sel_ch[g])
						down[g] <= 1'b1;
					else if (upd_ch[g])
						down[g] <= 1'b0;
				end
			end
		end
	endgenerate

	// ==========================================
	// wake-up delay
	logic [15:0] wake_cnt;           // cycles until settled
	logic [1:0]  waking;             // down channels being woken

	assign waking = upd_ch & down;

	// load delay at wake-up, count down to settled
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			wake_cnt <= 16'h0000;
		end else if (exec && waking != 2'b00) begin
			if (down == 2'b11)
				wake_cnt <= SUPPLY_LOW ? 16'(WAKE_BOTH3) : 16'(WAKE_BOTH5);
			else
				wake_cnt <= 16'(WAKE_ONE);
		end else if (wake_cnt != 16'h0000) begin
			wake_cnt <= wake_cnt - 16'h0001;
		end
	end

	// registered outputs
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			CODE_A  <= CODE_RESET;
			CODE_B  <= CODE_RESET;
			DOWN_A  <= 1'b0;
			DOWN_B  <= 1'b0;
			SETTLED <= 1'b1;
		end else begin
			CODE_A  <= dac_reg[0];
			CODE_B  <= dac_reg[1];
			DOWN_A  <= down[0];
			DOWN_B  <= down[1];
			SETTLED <= (wake_cnt == 16'h0000) && !(exec && waking != 2'b00);
		end
	end
endmodule : dsc_device

// ### logic/dsc_host.sv
module dsc_host #(
	parameter int HALF = dsc_pkg::SCK_HALF_CYC     // clk cycles per sck half period
) (
	// clock and reset
	input  wire logic        CLK,
	input  wire logic        RST,
	// axi4-lite write address
	input  wire logic [7:0]  AWADDR,
	input  wire logic        AWVALID,
	output logic             AWREADY,
	// axi4-lite write data
	input  wire logic [31:0] WDATA,
	input  wire logic [3:0]  WSTRB,
	input  wire logic        WVALID,
	output logic             WREADY,
	// axi4-lite write response
	output logic [1:0]       BRESP,
	output logic             BVALID,
	input  wire logic        BREADY,
	// axi4-lite read
	input  wire logic [7:0]  ARADDR,
	input  wire logic        ARVALID,
	output logic             ARREADY,
	output logic [31:0]      RDATA,
	output logic [1:0]       RRESP,
	output logic             RVALID,
	input  wire logic        RREADY,
	// link
	dsc_link_if.host         LINK
);
	import dsc_pkg::*;

	typedef enum {IDLE, LOW, HIGH, DONE} dsc_state_t;

	// ==========================================
	// axi write path
	logic        aw_got;             // address taken, awaiting data
	logic        w_got;              // data taken
	logic [7:0]  aw_addr;
	logic [31:0] w_data;
	logic        start;              // launch a frame
	logic        busy;

	assign AWREADY = ~aw_got & ~BVALID;
	assign WREADY  = ~w_got & ~BVALID;

	// capture address and data in either order
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			aw_got <= 1'b0;
			w_got  <= 1'b0;
			aw_addr <= 8'h00;
			w_data  <= 32'h0000_0000;
			BVALID  <= 1'b0;
			BRESP   <= 2'h0;
		end else begin
			if (AWVALID && AWREADY) begin
				aw_got  <= 1'b1;
				aw_addr <= AWADDR;
			end
			if (WVALID && WREADY) begin
				w_got  <= 1'b1;
				w_data <= WDATA;
			end
			if (aw_got && w_got && !BVALID) begin
				// busy command write or unmapped address is slverr
				BRESP  <= (aw_addr == OFF_CMD && !busy) ? 2'h0 : 2'h2;
				BVALID <= 1'b1;
				aw_got <= 1'b0;
				w_got  <= 1'b0;
			end
			if (BVALID && BREADY)
				BVALID <= 1'b0;
		end
	end
	assign start = aw_got && w_got && !BVALID && aw_addr == OFF_CMD && !busy;

	// ==========================================
	// axi read path
	assign ARREADY = ~RVALID;
	// one-cycle read answer
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			RVALID <= 1'b0;
			RDATA  <= 32'h0000_0000;
			RRESP  <= 2'h0;
		end else if (ARVALID && ARREADY) begin
			RVALID <= 1'b1;
			RDATA  <= (ARADDR == OFF_STATUS) ? {31'h0, busy} : 32'h0000_0000;
			RRESP  <= (ARADDR == OFF_STATUS) ? 2'h0 : 2'h2;
		end else if (RVALID && RREADY) begin
			RVALID <= 1'b0;
		end
	end

	// ==========================================
	// frame engine
	dsc_state_t  state;
	logic [31:0] word;               // bits left, msb out first
	logic [5:0]  left;               // bits still to send
	logic [7:0]  tick;               // half-period divider

	assign busy = (state != IDLE);

	// divider and bit sequencer, data changes while sck low
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			state <= IDLE;
			word  <= 32'h0000_0000;
			left  <= 6'h00;
			tick  <= 8'h00;
			LINK.select_load_n  <= 1'b1;
			LINK.sck            <= 1'b0;
			LINK.serial_data_in <= 1'b0;
		end else begin
			case (state)
				IDLE: begin
					if (start) begin
						// long form puts 8 zero pad bits ahead
						word <= w_data[31] ? {8'h00, w_data[23:0]} : {w_data[23:0], 8'h00};
						left <= w_data[31] ? 6'(LONG_BITS) : 6'(WORD_BITS);
						tick <= 8'h00;
						LINK.select_load_n <= 1'b0;
						state <= LOW;
					end
				end
				LOW: begin
					// present bit, command first, msb first
					LINK.serial_data_in <= word[31];
					if (tick == 8'(HALF - 1)) begin
						tick <= 8'h00;
						LINK.sck <= 1'b1;
						word <= {word[30:0], 1'b0};
						left <= left - 6'h01;
						state <= HIGH;
					end else begin
						tick <= tick + 8'h01;
					end
				end
				HIGH: begin
					if (tick == 8'(HALF - 1)) begin
						tick <= 8'h00;
						LINK.sck <= 1'b0;
						state <= (left == 6'h00) ? DONE : LOW;
					end else begin
						tick <= tick + 8'h01;
					end
				end
				DONE: begin
					// raise select to execute after a low half period
					if (tick == 8'(HALF - 1)) begin
						tick <= 8'h00;
						LINK.select_load_n <= 1'b1;
						state <= IDLE;
					end else begin
						tick <= tick + 8'h01;
					end
				end
				default: state <= IDLE;
			endcase
		end
	end
endmodule : dsc_host

// ### testbench/dsc_link_chk.sv
module dsc_link_chk (
	// clock and reset
	input wire logic CLK,
	input wire logic RST,
	// link wires
	input wire logic select_load_n,
	input wire logic sck,
	input wire logic serial_data_in
);
	timeunit 1ns;
	timeprecision 100ps;
	// ==========================================
	// frame bit counter
	logic       sck_q; // sck one clock ago
	logic [5:0] bits;  // rising sck edges in this frame
	// edge finder for the link clock
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			sck_q <= 1'b0;
		end else begin
			sck_q <= sck;
		end
	end
	// cleared while deselected, so a stale count never leaks across frames
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			bits <= 6'h00;
		end else if (select_load_n) begin
			bits <= 6'h00;
		end else if (sck && !sck_q) begin
			bits <= bits + 6'h01;
		end
	end
	// ==========================================
	// wire checks
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (RST);
	chk_idle_clock_low: assert property (select_load_n |-> !sck)
		else $error("sck high while deselected");
	chk_frame_bit_count: assert property (
		$rose(select_load_n) |-> (bits == 6'h18 || bits == 6'h20))
		else $error("frame length not 24 or 32 bits");
	chk_sck_high_width: assert property ($rose(sck) |-> sck[*8] ##1 !sck)
		else $error("sck high half wrong");
	chk_sck_low_width: assert property ($fell(sck) |-> !sck[*8])
		else $error("sck low half too short");
	chk_data_hold_high: assert property (sck && $past(sck) |-> $stable(serial_data_in))
		else $error("data moved while sck high");
	chk_select_setup: assert property ($fell(select_load_n) |-> !sck[*4])
		else $error("sck rose too soon after select");
	chk_next_edge_bound: assert property (
		$fell(sck) |-> ##[1:9] (sck || select_load_n))
		else $error("link stalled inside frame");
	chk_frame_bounded: assert property ($fell(select_load_n) |-> ##[1:600] select_load_n)
		else $error("frame never closed");
	// main scenarios
	cover property ($rose(select_load_n) && bits == 6'h18);
	cover property ($rose(select_load_n) && bits == 6'h20);
	cover property ($fell(select_load_n));
endmodule : dsc_link_chk

// ### testbench/dual_dac_serial_command_port_test.sv
module dual_dac_serial_command_port_test import dsc_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;
	// ==========================================
	// stimulus and observed signals
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        supply_low = 1'b0; // 5 V wake figure until the low-supply case
	logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [3:0]  wstrb = 4'hF;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp, r;
	logic [31:0] rdata, d;
	logic [15:0] code_a, code_b;
	logic        down_a, down_b, settled;
	logic        sck_q = 1'b0;       // sck one clock ago
	logic [31:0] cap_sh = 32'h0;     // bits shifted in this frame
	logic [31:0] cap_n = 32'h0;      // bits seen this frame
	logic [31:0] cap_word, cap_cnt;  // last finished frame
	int          fails = 0, n_checks = 0, cycles = 0;
	dsc_link_if link ();
	dsc_host i_dsc_host (.CLK(clk), .RST(rst), .AWADDR(awaddr), .AWVALID(awvalid),
		.AWREADY(awready), .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready),
		.BRESP(bresp), .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid),
		.ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready),
		.LINK(link));
	// short wake counts keep the run brief
	dsc_device #(.WAKE_ONE(10), .WAKE_BOTH5(20), .WAKE_BOTH3(30)) i_dsc_device (.CLK(clk),
		.RST(rst), .LINK(link), .SUPPLY_LOW(supply_low), .CODE_A(code_a), .CODE_B(code_b),
		.DOWN_A(down_a), .DOWN_B(down_b), .SETTLED(settled));
	dsc_link_chk i_dsc_link_chk (.CLK(clk), .RST(rst), .select_load_n(link.select_load_n),
		.sck(link.sck), .serial_data_in(link.serial_data_in));
	always #2.5 clk = ~clk;
	// ==========================================
	// wire monitor: rebuilds each frame from the pins
	always @(posedge clk) begin
		sck_q <= link.sck;
		if (link.select_load_n) begin
			if (cap_n != 0) begin
				cap_word <= cap_sh;
				cap_cnt <= cap_n;
			end
			cap_sh <= 32'h0;
			cap_n <= 32'h0;
		end else if (link.sck && !sck_q) begin
			cap_sh <= {cap_sh[30:0], link.serial_data_in};
			cap_n <= cap_n + 32'h1;
		end
	end
	// ==========================================
	// checking and closing
	task automatic check(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			fails++;
			$display("ERROR at %0t: got %h expected %h", $time, g, e);
		end
	endtask : check
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : wrap_up
	// hang guard, far above the few thousand cycles needed
	always @(posedge clk) begin
		cycles++;
		if (cycles == 30000) begin
			fails++;
			$display("ERROR at %0t: timeout", $time);
			wrap_up();
		end
	end
	// ==========================================
	// bus tasks: hold each request until its ready is seen
	task automatic axi_write(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rr);
		logic done;
		done = 1'b0;
		@(posedge clk);
		awaddr <= a;
		wdata <= v;
		{awvalid, wvalid, bready} <= 3'h7;
		while (!done) begin
			@(posedge clk);
			if (awvalid && awready) begin
				awvalid <= 1'b0;
			end
			if (wvalid && wready) begin
				wvalid <= 1'b0;
			end
			if (bvalid) begin
				rr = bresp;
				bready <= 1'b0;
				done = 1'b1;
			end
		end
	endtask : axi_write
	task automatic axi_read(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rr);
		logic done;
		done = 1'b0;
		@(posedge clk);
		araddr <= a;
		{arvalid, rready} <= 2'h3;
		while (!done) begin
			@(posedge clk);
			if (arvalid && arready) begin
				arvalid <= 1'b0;
			end
			if (rvalid) begin
				v = rdata;
				rr = rresp;
				rready <= 1'b0;
				done = 1'b1;
			end
		end
	endtask : axi_read
	// one command frame, then the wire image is compared with what was asked
	task automatic send(input logic [3:0] c, input logic [3:0] a, input logic [15:0] v,
		input logic lng);
		logic [31:0] st;
		logic [1:0]  sr;
		axi_write(OFF_CMD, {lng, 7'h00, c, a, v}, sr);
		check({30'h0, sr}, 32'h0);
		st = 32'h1;
		while (st[0] !== 1'b0) begin
			axi_read(OFF_STATUS, st, sr);
		end
		repeat (10) @(posedge clk);
		check(cap_word, {8'h00, c, a, v});
		check(cap_cnt, lng ? 32'h20 : 32'h18);
	endtask : send
	task automatic expect_out(input logic [15:0] ea, input logic [15:0] eb, input logic [1:0] ed);
		check({code_a, code_b}, {ea, eb});
		check({30'h0, down_a, down_b}, {30'h0, ed});
	endtask : expect_out
	// ==========================================
	// main sequence
	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		expect_out(16'h0000, 16'h0000, 2'b00);
		check({31'h0, settled}, 32'h1);
		send(CMD_WRITE, ADDR_A, 16'h1234, 1'b1);
		expect_out(16'h0000, 16'h0000, 2'b00);
		send(CMD_UPDATE, ADDR_A, 16'hFFFF, 1'b0);
		expect_out(16'h1234, 16'h0000, 2'b00);
		send(CMD_WRITE_UPD, ADDR_B, 16'hABCD, 1'b0);
		expect_out(16'h1234, 16'hABCD, 2'b00);
		send(CMD_WRITE_ALL, ADDR_A, 16'h5555, 1'b1);
		expect_out(16'h5555, 16'hABCD, 2'b00);
		send(CMD_POWER_DOWN, ADDR_ALL, 16'h9999, 1'b0);
		expect_out(16'h5555, 16'hABCD, 2'b11);
		send(CMD_NOP, ADDR_ALL, 16'h7777, 1'b0);
		expect_out(16'h5555, 16'hABCD, 2'b11);
		send(CMD_WRITE, ADDR_B, 16'h0101, 1'b0);
		expect_out(16'h5555, 16'hABCD, 2'b11);
		send(CMD_UPDATE, ADDR_A, 16'h0000, 1'b0);
		expect_out(16'h5555, 16'hABCD, 2'b01);
		check({31'h0, settled}, 32'h0);
		// 5 V figure for both down is over here, the 3 V one would not be
		repeat (16) @(posedge clk);
		check({31'h0, settled}, 32'h1);
		send(CMD_UPDATE, ADDR_ALL, 16'h0000, 1'b0);
		expect_out(16'h5555, 16'h0101, 2'b00);
		check({31'h0, settled}, 32'h0);
		// single-channel wake is the shortest figure
		repeat (8) @(posedge clk);
		check({31'h0, settled}, 32'h1);
		// low supply selects the longest wake figure
		supply_low <= 1'b1;
		send(CMD_POWER_DOWN, ADDR_ALL, 16'hFFFF, 1'b1);
		expect_out(16'h5555, 16'h0101, 2'b11);
		send(CMD_UPDATE, ADDR_ALL, 16'h0000, 1'b0);
		check({31'h0, settled}, 32'h0);
		repeat (16) @(posedge clk);
		check({31'h0, settled}, 32'h0);
		repeat (16) @(posedge clk);
		check({31'h0, settled}, 32'h1);
		expect_out(16'h5555, 16'h0101, 2'b00);
		// unmapped places answer with a slave error
		axi_write(8'h08, 32'h0030_1111, r);
		check({30'h0, r}, 32'h2);
		axi_read(8'h10, d, r);
		check({30'h0, r}, 32'h2);
		check(d, 32'h0);
		// a command while a frame runs is refused and never sent
		axi_write(OFF_CMD, {8'h00, CMD_NOP, ADDR_ALL, 16'h0000}, r);
		check({30'h0, r}, 32'h0);
		axi_write(OFF_CMD, {8'h00, CMD_WRITE_UPD, ADDR_A, 16'h2222}, r);
		check({30'h0, r}, 32'h2);
		repeat (600) @(posedge clk);
		check(cap_word, {8'h00, CMD_NOP, ADDR_ALL, 16'h0000});
		expect_out(16'h5555, 16'h0101, 2'b00);
		wrap_up();
	end
endmodule : dual_dac_serial_command_port_test
